// ---- src/csw_control_status.sv ----
// control/status register, write protection and reset timing behind a two-wire serial bus
`timescale 1ns/1ps
`default_nettype none

module csw_control_status #(
   parameter int CYCLES_PER_MS = csw_pkg::CYCLES_PER_MS   // clock cycles in one millisecond tick
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic sclIn,              // serial clock pin
   input wire logic sdaIn,              // serial data pin level
   output logic sdaOut,                 // serial data drive value (always low)
   output logic sdaOe,                  // high while pulling serial data low
   input wire logic writeProtect,       // write-protect pin
   input wire logic supplyBelow,        // supply comparator: below threshold
   input wire logic manualResetInput,   // manual reset pin
   input wire logic monitor2Above,      // monitor 2 comparator
   input wire logic monitor3Above,      // monitor 3 comparator
   input wire logic [7:0] memWriteAddr, // memory address of a pending write
   input wire logic memLockedAttempt,   // pulse: memory write hit locked region
   output logic supplyResetOutput,
   output logic monitor2Output,
   output logic monitor3Output,
   output logic potVolatileWriteOk,
   output logic potNonvolatileWriteOk,
   output logic memWriteOk,
   output logic nvBusy
);

   // refuse a timebase too short to make a tick
   if (CYCLES_PER_MS < 2) begin : gBadTick
      $error("CYCLES_PER_MS must be at least 2");
   end

   localparam int DIV_W = $clog2(CYCLES_PER_MS);
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CYCLES_PER_MS - 1);

   // reset hold time in ms for a delay-select pair
   function automatic logic [csw_pkg::MS_CNT_W-1:0] holdMs(input logic [1:0] sel);
      case (sel)
         2'b00: holdMs = csw_pkg::MS_CNT_W'(csw_pkg::HOLD_MS_00);
         2'b01: holdMs = csw_pkg::MS_CNT_W'(csw_pkg::HOLD_MS_01);
         2'b10: holdMs = csw_pkg::MS_CNT_W'(csw_pkg::HOLD_MS_10);
         default: holdMs = csw_pkg::MS_CNT_W'(csw_pkg::HOLD_MS_11);
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // input synchronisers
   ////////////////////////////////////////////////////////////////////////////

   logic [6:0] rawIn;     // pins gathered
   logic [6:0] meta_ff;   // first stage, read only by second stage
   logic [6:0] sync_ff;   // second stage, safe to use
   logic [3:0] prev_ff;   // previous scl, sda, m2, m3 for edge finding

   assign rawIn = {sclIn, sdaIn, writeProtect, supplyBelow, manualResetInput, monitor2Above, monitor3Above};

   // two flops per pin; prev copies only the second stage
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         // clock and data start at their idle high level so leaving reset makes no false edge
         meta_ff <= 7'h60;
         sync_ff <= 7'h60;
         prev_ff <= 4'hc;
      end else begin
         meta_ff <= rawIn;
         sync_ff <= meta_ff;
         prev_ff <= {sync_ff[6], sync_ff[5], sync_ff[1], sync_ff[0]};
      end
   end

   logic scl, sda, wp, supLow, mrPin, mon2, mon3;
   assign {scl, sda, wp, supLow, mrPin, mon2, mon3} = sync_ff;

   logic sclRise, sclFall, startCond, stopCond, mon2Rise, mon3Rise;
   assign sclRise = scl & ~prev_ff[3];
   assign sclFall = ~scl & prev_ff[3];
   assign startCond = scl & prev_ff[3] & ~sda & prev_ff[2];   // data falls, clock high
   assign stopCond = scl & prev_ff[3] & sda & ~prev_ff[2];    // data rises, clock high
   assign mon2Rise = mon2 & ~prev_ff[1];
   assign mon3Rise = mon3 & ~prev_ff[0];

   ////////////////////////////////////////////////////////////////////////////
   // millisecond timebase
   ////////////////////////////////////////////////////////////////////////////

   logic [DIV_W-1:0] div_ff, nxt_div;
   logic msTick;

   // one-cycle enable every millisecond
   always_comb begin
      msTick = (div_ff == DIV_LAST);
      nxt_div = msTick ? '0 : div_ff + DIV_W'(1);
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         div_ff <= '0;
      end else begin
         div_ff <= nxt_div;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus engine and control register
   ////////////////////////////////////////////////////////////////////////////

   csw_pkg::csw_bus_t state_ff, nxt_state;       // bit-level engine
   csw_pkg::csw_phase_t phase_ff, nxt_phase;     // byte within frame
   logic [7:0] shift_ff, nxt_shift;              // receive / transmit shifter
   logic [3:0] bitCnt_ff, nxt_bitCnt;            // bits moved in this byte
   logic goTx_ff, nxt_goTx;                      // after ack slot, transmit
   logic oe_ff, nxt_oe;                          // data line pull-down
   logic dataSeen_ff, nxt_dataSeen;              // one data byte already taken
   logic pending_ff, nxt_pending;                // a byte waits for STOP
   logic [7:0] data_ff, nxt_data;                // the waiting byte
   csw_pkg::csw_ctrl_t ctrl_ff, nxt_ctrl;        // the control register
   logic [2:0] nvMs_ff, nxt_nvMs;                // ms left in nonvolatile store
   logic [3:0] nvStage_ff, nxt_nvStage;          // lock and delay bits being stored

   logic welOk;        // byte may be acked under the enable latch
   logic [7:0] wrByte;

   // combinational next state for the bus and the register
   always_comb begin
      nxt_state = state_ff;
      nxt_phase = phase_ff;
      nxt_shift = shift_ff;
      nxt_bitCnt = bitCnt_ff;
      nxt_goTx = goTx_ff;
      nxt_oe = oe_ff;
      nxt_dataSeen = dataSeen_ff;
      nxt_pending = pending_ff;
      nxt_data = data_ff;
      nxt_ctrl = ctrl_ff;
      nxt_nvMs = nvMs_ff;
      nxt_nvStage = nvStage_ff;
      wrByte = data_ff;
      // 02h and 00h are the only bytes a cleared latch may take
      welOk = ctrl_ff.write_enable_latch | (shift_ff == csw_pkg::CMD_SET_WEL) | (shift_ff == csw_pkg::CMD_CLR_WEL);

      // nonvolatile store runs on the ms tick
      if (nvMs_ff != 3'h0 && msTick) begin
         nxt_nvMs = nvMs_ff - 3'h1;
         if (nvMs_ff == 3'h1) begin
            {nxt_ctrl.delaySelHigh, nxt_ctrl.lockHigh, nxt_ctrl.lockLow, nxt_ctrl.delaySelLow} = nvStage_ff;
            nxt_ctrl.unlock = 1'b0;
         end
      end

      if (startCond) begin
         // start or repeated start: any half-built write is dropped
         nxt_state = csw_pkg::BUS_RX;
         nxt_phase = csw_pkg::PH_DEV;
         nxt_bitCnt = 4'h0;
         nxt_goTx = 1'b0;
         nxt_oe = 1'b0;
         nxt_dataSeen = 1'b0;
         nxt_pending = 1'b0;
      end else if (stopCond) begin
         nxt_state = csw_pkg::BUS_IDLE;
         nxt_oe = 1'b0;
         nxt_pending = 1'b0;
         // commit only when the stop's own clock rise is the one clock seen after the data ack
         if (pending_ff && state_ff == csw_pkg::BUS_RX && bitCnt_ff == 4'h1) begin
            if (ctrl_ff.unlock && !wrByte[2]) begin
               // third step: nonvolatile store
               nxt_ctrl.write_enable_latch = wrByte[1];
               if (!wp) begin
                  nxt_ctrl.flag2 = wrByte[6] & mon2;
                  nxt_ctrl.flag3 = wrByte[5] & mon3;
                  nxt_nvStage = {wrByte[7], wrByte[4], wrByte[3], wrByte[0]};
                  nxt_nvMs = 3'(csw_pkg::NV_WRITE_MS);
               end
            end else if (ctrl_ff.unlock) begin
               // bit 2 set in third step: only the latches move
               nxt_ctrl.unlock = 1'b1;
               nxt_ctrl.write_enable_latch = wrByte[1];
            end else if (wrByte == csw_pkg::CMD_SET_UNLOCK) begin
               if (!wp) begin
                  nxt_ctrl.unlock = 1'b1;
               end
               nxt_ctrl.write_enable_latch = 1'b1;
            end else if (wrByte == csw_pkg::CMD_SET_WEL) begin
               nxt_ctrl.write_enable_latch = 1'b1;
            end else if (wrByte == csw_pkg::CMD_CLR_WEL) begin
               nxt_ctrl.write_enable_latch = 1'b0;
            end
         end
      end else begin
         case (state_ff)
            csw_pkg::BUS_IDLE: begin
               nxt_oe = 1'b0;   // ignore everything until a start
            end
            csw_pkg::BUS_RX: begin
               if (sclRise && bitCnt_ff != 4'h8) begin
                  nxt_shift = {shift_ff[6:0], sda};
                  nxt_bitCnt = bitCnt_ff + 4'h1;
               end else if (sclFall && bitCnt_ff != 4'h8) begin
                  // a whole clock pulse after the data ack spoils the commit
                  nxt_pending = 1'b0;
               end else if (sclFall && bitCnt_ff == 4'h8) begin
                  nxt_state = csw_pkg::BUS_SKIP;   // default: no ack
                  case (phase_ff)
                     csw_pkg::PH_DEV: begin
                        // no ack while the store is busy
                        if (shift_ff == csw_pkg::WR_DEV_BYTE && nvMs_ff == 3'h0) begin
                           nxt_state = csw_pkg::BUS_ACK;
                           nxt_phase = csw_pkg::PH_REG;
                        end else if (shift_ff == csw_pkg::RD_DEV_BYTE && nvMs_ff == 3'h0) begin
                           nxt_state = csw_pkg::BUS_ACK;
                           nxt_goTx = 1'b1;
                        end
                     end
                     csw_pkg::PH_REG: begin
                        if (shift_ff == csw_pkg::CTRL_REG_ADDR) begin
                           nxt_state = csw_pkg::BUS_ACK;
                           nxt_phase = csw_pkg::PH_DATA;
                        end
                     end
                     csw_pkg::PH_DATA: begin
                        if (!dataSeen_ff && welOk) begin
                           nxt_state = csw_pkg::BUS_ACK;
                           nxt_pending = 1'b1;
                           nxt_data = shift_ff;
                           nxt_dataSeen = 1'b1;
                        end else begin
                           nxt_pending = 1'b0;
                        end
                     end
                     default: begin
                        nxt_state = csw_pkg::BUS_SKIP;
                     end
                  endcase
                  nxt_oe = (nxt_state == csw_pkg::BUS_ACK);
               end
            end
            csw_pkg::BUS_ACK: begin
               // ack held through one clock pulse, released on its fall
               if (sclFall) begin
                  nxt_bitCnt = 4'h0;
                  if (goTx_ff) begin
                     // read returns the register untouched by the read itself
                     nxt_state = csw_pkg::BUS_TX;
                     nxt_shift = ctrl_ff;
                     nxt_oe = ~ctrl_ff[7];
                     nxt_bitCnt = 4'h1;
                  end else begin
                     nxt_state = csw_pkg::BUS_RX;
                     nxt_oe = 1'b0;
                  end
               end
            end
            csw_pkg::BUS_TX: begin
               if (sclFall) begin
                  if (bitCnt_ff == 4'h8) begin
                     nxt_state = csw_pkg::BUS_TXACK;
                     nxt_oe = 1'b0;
                  end else begin
                     nxt_oe = ~shift_ff[3'(4'h7 - bitCnt_ff)];
                     nxt_bitCnt = bitCnt_ff + 4'h1;
                  end
               end
            end
            csw_pkg::BUS_TXACK: begin
               // one byte only, then back to idle whatever the master answers
               if (sclFall) begin
                  nxt_state = csw_pkg::BUS_IDLE;
                  nxt_goTx = 1'b0;
               end
            end
            csw_pkg::BUS_SKIP: begin
               nxt_oe = 1'b0;
               nxt_pending = 1'b0;
            end
            default: begin
               nxt_state = csw_pkg::BUS_IDLE;
               nxt_oe = 1'b0;
            end
         endcase
      end

      // locked-region memory attempt drops the unlock
      if (memLockedAttempt) begin
         nxt_ctrl.unlock = 1'b0;
      end

      // monitor low or rising clears its flag; the clear wins over a same-cycle write set
      if (!mon2 || mon2Rise) begin
         nxt_ctrl.flag2 = 1'b0;
      end
      if (!mon3 || mon3Rise) begin
         nxt_ctrl.flag3 = 1'b0;
      end
   end

   // register the bus and control state
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_ff <= csw_pkg::BUS_IDLE;
         phase_ff <= csw_pkg::PH_DEV;
         shift_ff <= 8'h00;
         bitCnt_ff <= 4'h0;
         goTx_ff <= 1'b0;
         oe_ff <= 1'b0;
         dataSeen_ff <= 1'b0;
         pending_ff <= 1'b0;
         data_ff <= 8'h00;
         ctrl_ff <= csw_pkg::CTRL_RESET;
         nvMs_ff <= 3'h0;
         nvStage_ff <= 4'h0;
      end else begin
         state_ff <= nxt_state;
         phase_ff <= nxt_phase;
         shift_ff <= nxt_shift;
         bitCnt_ff <= nxt_bitCnt;
         goTx_ff <= nxt_goTx;
         oe_ff <= nxt_oe;
         dataSeen_ff <= nxt_dataSeen;
         pending_ff <= nxt_pending;
         data_ff <= nxt_data;
         ctrl_ff <= nxt_ctrl;
         nvMs_ff <= nxt_nvMs;
         nvStage_ff <= nxt_nvStage;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // supply reset timing
   ////////////////////////////////////////////////////////////////////////////

   logic [csw_pkg::MS_CNT_W-1:0] hold_ff, nxt_hold;   // ms left of reset hold
   logic mrDeb_ff, nxt_mrDeb;                         // manual reset, debounced on ms tick
   logic supRst_ff, nxt_supRst;
   logic mon2_ff, mon3_ff;

   // the manual pin only moves once per ms, so contact bounce is filtered out
   always_comb begin
      nxt_mrDeb = msTick ? mrPin : mrDeb_ff;
      if (supLow || mrDeb_ff) begin
         nxt_hold = holdMs({ctrl_ff.delaySelHigh, ctrl_ff.delaySelLow});
      end else if (msTick && hold_ff != '0) begin
         nxt_hold = hold_ff - csw_pkg::MS_CNT_W'(1);
      end else begin
         nxt_hold = hold_ff;
      end
      nxt_supRst = supLow | mrDeb_ff | (hold_ff != '0);
   end

   // output held high from reset until the hold time has run out
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         hold_ff <= csw_pkg::MS_CNT_W'(csw_pkg::HOLD_MS_01);
         mrDeb_ff <= 1'b0;
         supRst_ff <= 1'b1;
         mon2_ff <= 1'b0;
         mon3_ff <= 1'b0;
      end else begin
         hold_ff <= nxt_hold;
         mrDeb_ff <= nxt_mrDeb;
         supRst_ff <= nxt_supRst;
         mon2_ff <= mon2;
         mon3_ff <= mon3;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs and write permissions
   ////////////////////////////////////////////////////////////////////////////

   logic lockAny;
   logic memLocked;
   assign lockAny = ctrl_ff.lockHigh | ctrl_ff.lockLow;

   // region map of the lock selects
   always_comb begin
      case ({ctrl_ff.lockHigh, ctrl_ff.lockLow})
         2'b00: memLocked = 1'b0;
         2'b01: memLocked = (memWriteAddr >= csw_pkg::LOCK_QUARTER_BASE);
         2'b10: memLocked = (memWriteAddr >= csw_pkg::LOCK_HALF_BASE);
         default: memLocked = 1'b1;
      endcase
   end

   assign sdaOut = 1'b0;
   assign sdaOe = oe_ff;
   assign supplyResetOutput = supRst_ff;
   assign monitor2Output = mon2_ff;
   assign monitor3Output = mon3_ff;
   assign nvBusy = (nvMs_ff != 3'h0);
   assign potVolatileWriteOk = ctrl_ff.write_enable_latch & ~lockAny;
   assign potNonvolatileWriteOk = ctrl_ff.write_enable_latch & ~lockAny & ~wp;
   assign memWriteOk = ctrl_ff.write_enable_latch & ~wp & ~memLocked;

endmodule // csw_control_status
`default_nettype wire

// ---- include/csw_pkg.sv ----
// shared constants and types for the control/status write-protect block
`default_nettype none
package csw_pkg;

   // control byte layout, msb first
   typedef struct packed {
      logic delaySelHigh;   // reset-delay select, high bit (nonvolatile)
      logic flag2;          // monitor 2 status flag (volatile)
      logic flag3;          // monitor 3 status flag (volatile)
      logic lockHigh;       // lock select, high bit (nonvolatile)
      logic lockLow;        // lock select, low bit (nonvolatile)
      logic unlock;         // register write unlock (volatile)
      logic write_enable_latch;            // write enable latch (volatile)
      logic delaySelLow;    // reset-delay select, low bit (nonvolatile)
   } csw_ctrl_t;

   // bus byte codes
   localparam logic [7:0] WR_DEV_BYTE = 8'ha4;   // 1010010 + write
   localparam logic [7:0] RD_DEV_BYTE = 8'ha5;   // 1010010 + read
   localparam logic [7:0] CTRL_REG_ADDR = 8'hff;
   localparam logic [7:0] CMD_SET_WEL = 8'h02;
   localparam logic [7:0] CMD_SET_UNLOCK = 8'h06;
   localparam logic [7:0] CMD_CLR_WEL = 8'h00;

   // reset value: volatile bits clear, delay select 01, no lock
   localparam csw_ctrl_t CTRL_RESET = 8'h01;

   // lock region lower bounds
   localparam logic [7:0] LOCK_QUARTER_BASE = 8'hc0;
   localparam logic [7:0] LOCK_HALF_BASE = 8'h80;

   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int NS_PER_MS = 1000000;
   localparam int CYCLES_PER_MS = (NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int NV_WRITE_MS = 5;
   localparam int HOLD_MS_00 = 50;
   localparam int HOLD_MS_01 = 100;
   localparam int HOLD_MS_10 = 200;
   localparam int HOLD_MS_11 = 300;
   localparam int MS_CNT_W = 9;

   // bus engine states
   typedef enum logic [2:0] {
      BUS_IDLE,
      BUS_RX,
      BUS_ACK,
      BUS_TX,
      BUS_TXACK,
      BUS_SKIP
   } csw_bus_t;

   // which byte of a frame is being received
   typedef enum logic [1:0] {
      PH_DEV,
      PH_REG,
      PH_DATA
   } csw_phase_t;

endpackage
`default_nettype wire

// ---- tb/csw_monitor.sv ----
// port checker for the control/status block
`timescale 1ns/1ps
`default_nettype none
module csw_monitor #(
   parameter int CYCLES_PER_MS = 20
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic sdaOut,
   input wire logic sdaOe,
   input wire logic writeProtect,
   input wire logic supplyBelow,
   input wire logic manualResetInput,
   input wire logic monitor2Above,
   input wire logic monitor3Above,
   input wire logic [7:0] memWriteAddr,
   input wire logic supplyResetOutput,
   input wire logic monitor2Output,
   input wire logic monitor3Output,
   input wire logic potVolatileWriteOk,
   input wire logic potNonvolatileWriteOk,
   input wire logic memWriteOk,
   input wire logic nvBusy
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   int quietCnt_ff = 0; // cycles since every reset source went quiet
   int manCnt_ff = 0; // cycles the manual pin has been high
   int busyCnt_ff = 0; // cycles of the running store
   // counters are kept plain so long ms figures need no repetition
   always_ff @(posedge clk) begin
      quietCnt_ff <= (!reset_n || supplyBelow || manualResetInput) ? 0 : quietCnt_ff + 1;
      manCnt_ff <= manualResetInput ? manCnt_ff + 1 : 0;
      busyCnt_ff <= nvBusy ? busyCnt_ff + 1 : 0;
   end
   reset_state_a: assert property (disable iff (1'b0) !reset_n |=> supplyResetOutput && !nvBusy && !sdaOe)
      else $error("outputs not in reset state");
   supply_low_a: assert property (supplyBelow [*4] |-> supplyResetOutput)
      else $error("supply low without reset");
   hold_time_a: assert property ($fell(supplyResetOutput) |-> quietCnt_ff >= 49 * CYCLES_PER_MS)
      else $error("reset released early");
   manual_force_a: assert property (manCnt_ff > 2 * CYCLES_PER_MS |-> supplyResetOutput)
      else $error("manual reset ignored");
   store_len_a: assert property ($fell(nvBusy) |-> busyCnt_ff >= 4 * CYCLES_PER_MS)
      else $error("store too short");
   store_max_a: assert property (busyCnt_ff <= 5 * CYCLES_PER_MS + 4)
      else $error("store too long");
   busy_quiet_a: assert property (nvBusy |-> !sdaOe && sdaOut == 1'b0)
      else $error("bus driven during store");
   protect_gate_a: assert property (writeProtect [*4] |-> !potNonvolatileWriteOk && !memWriteOk)
      else $error("write allowed under protect");
   lock_map_a: assert property (memWriteOk && memWriteAddr >= 8'hc0 |-> potVolatileWriteOk)
      else $error("upper quarter writable while locked");
   nv_pot_a: assert property (potNonvolatileWriteOk |-> potVolatileWriteOk)
      else $error("pot store allowed while locked");
   mon2_track_a: assert property (monitor2Above [*4] |-> monitor2Output)
      else $error("monitor 2 output stuck low");
   mon3_track_a: assert property (!monitor3Above [*4] |-> !monitor3Output)
      else $error("monitor 3 output stuck high");
   store_c: cover property ($fell(nvBusy));
   ack_c: cover property ($rose(sdaOe));
   release_c: cover property ($fell(supplyResetOutput));
endmodule // csw_monitor
bind csw_control_status csw_monitor #(.CYCLES_PER_MS(CYCLES_PER_MS)) csw_monitor_i (.clk(clk), .reset_n(reset_n),
   .sdaOut(sdaOut), .sdaOe(sdaOe), .writeProtect(writeProtect), .supplyBelow(supplyBelow),
   .manualResetInput(manualResetInput), .monitor2Above(monitor2Above), .monitor3Above(monitor3Above),
   .memWriteAddr(memWriteAddr), .supplyResetOutput(supplyResetOutput), .monitor2Output(monitor2Output),
   .monitor3Output(monitor3Output), .potVolatileWriteOk(potVolatileWriteOk),
   .potNonvolatileWriteOk(potNonvolatileWriteOk), .memWriteOk(memWriteOk), .nvBusy(nvBusy));
`default_nettype wire

// ---- tb/csw_host_model.sv ----
// two-wire bus master model for the control/status block
`timescale 1ns/1ps
`default_nettype none
module csw_host_model (
   input wire logic clk,
   input wire logic sdaLine,
   output logic scl,
   output logic sda
);
   // idle: clock parked high, data left to the pull-up
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   task automatic tk(input int n);
      repeat (n) @(posedge clk);
   endtask
   // one 80 ns bit: 5 clocks low, 3 high, data read late in the high phase
   task automatic bit_io(input logic b, output logic r);
      tk(1);
      sda <= b;
      tk(4);
      scl <= 1'b1;
      tk(3);
      r = sdaLine;
      scl <= 1'b0;
   endtask
   task automatic start();
      tk(1);
      sda <= 1'b1;
      tk(4);
      scl <= 1'b1;
      tk(4);
      sda <= 1'b0;
      tk(4);
      scl <= 1'b0;
   endtask
   task automatic stop();
      tk(1);
      sda <= 1'b0;
      tk(4);
      scl <= 1'b1;
      tk(4);
      sda <= 1'b1;
      tk(4);
   endtask
   task automatic put(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(b[i], r);
      bit_io(1'b1, r);
      ack = !r;
   endtask
   // register write with n data bytes; ack of the last byte returned
   task automatic wr(input logic [7:0] d, input int n, output logic ack);
      start();
      put(csw_pkg::WR_DEV_BYTE, ack);
      put(csw_pkg::CTRL_REG_ADDR, ack);
      repeat (n) put(d, ack);
      stop();
   endtask
   // random read: one byte, master answers with nack then stop
   task automatic rd(output logic [7:0] d);
      logic a;
      start();
      put(csw_pkg::WR_DEV_BYTE, a);
      put(csw_pkg::CTRL_REG_ADDR, a);
      start();
      put(csw_pkg::RD_DEV_BYTE, a);
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(1'b1, a);
      stop();
   endtask
endmodule // csw_host_model
`default_nettype wire

// ---- tb/csw_control_status_write_protect_test.sv ----
// self-checking bench for the control/status block
`timescale 1ns/1ps
`default_nettype none
module csw_control_status_write_protect_test;
   localparam int CPM = 20; // short ms tick keeps the run small
   logic clk = 1'b0;
   logic resetN = 1'b0;
   logic wp = 1'b0;
   logic below = 1'b0;
   logic manual = 1'b0;
   logic mon2In = 1'b1;
   logic mon3In = 1'b0; // monitor 3 starts low so a flag write is masked
   logic lockHit = 1'b0; // pulse: memory write hit the locked region
   logic [7:0] addr = 8'hc0;
   logic scl, hostSda, sdaOut, sdaOe, rstOut, potV, potN, memOk, nvBusy, ack;
   logic [7:0] rv;
   int badCount = 0;
   int checksDone = 0;
   int cyc = 0;
   wire logic sdaLine = sdaOe ? sdaOut : hostSda; // pull-up wins when nobody pulls
   always #5 clk = ~clk;
   csw_control_status #(.CYCLES_PER_MS(CPM)) csw_control_status_i (.clk(clk), .reset_n(resetN), .sclIn(scl),
      .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .writeProtect(wp), .supplyBelow(below),
      .manualResetInput(manual), .monitor2Above(mon2In), .monitor3Above(mon3In), .memWriteAddr(addr),
      .memLockedAttempt(lockHit), .supplyResetOutput(rstOut), .monitor2Output(), .monitor3Output(),
      .potVolatileWriteOk(potV), .potNonvolatileWriteOk(potN), .memWriteOk(memOk), .nvBusy(nvBusy));
   csw_host_model csw_host_model_i (.clk(clk), .sdaLine(sdaLine), .scl(scl), .sda(hostSda));
   task automatic give_verdict();
      if (badCount == 0 && checksDone > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      checksDone++;
      if (s !== e) begin
         badCount++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   // bounded wait for a flag to drop; returns cycles waited
   task automatic until_low(ref logic f, input int lim, output int k);
      k = 0;
      while (f !== 1'b0 && k < lim) begin
         @(posedge clk);
         k++;
      end
   endtask
   // hang guard: the whole sequence needs well under this
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         badCount++;
         give_verdict();
      end
   end
   initial begin
      int k;
      repeat (20) @(posedge clk);
      resetN <= 1'b1;
      until_low(rstOut, 3000, k);
      chk("boot hold", 8'h01, 8'((k >= 99 * CPM) && (k <= 102 * CPM)));
      csw_host_model_i.rd(rv);
      chk("reset value", 8'h01, rv);
      csw_host_model_i.wr(8'h06, 1, ack);
      chk("ack no wel", 8'h00, 8'(ack));
      csw_host_model_i.wr(8'h02, 1, ack);
      csw_host_model_i.rd(rv);
      chk("wel set", 8'h03, rv);
      csw_host_model_i.wr(8'h06, 1, ack);
      csw_host_model_i.rd(rv);
      chk("unlock set", 8'h07, rv);
      chk("mem ok", 8'h01, 8'({potV, memOk} == 2'b11));
      csw_host_model_i.wr(8'h6a, 2, ack);
      chk("second ack", 8'h00, 8'(ack));
      csw_host_model_i.rd(rv);
      chk("aborted", 8'h07, rv);
      csw_host_model_i.wr(8'h6a, 1, ack);
      chk("store busy", 8'h01, 8'(nvBusy));
      until_low(nvBusy, 8 * CPM, k);
      csw_host_model_i.rd(rv);
      chk("stored", 8'h4a, rv);
      chk("lock c0", 8'h00, 8'({potV, memOk}));
      addr <= 8'hbf;
      @(posedge clk);
      @(posedge clk);
      chk("lock bf", 8'h01, 8'(memOk));
      csw_host_model_i.wr(8'h06, 1, ack);
      csw_host_model_i.wr(8'hbe, 1, ack);
      until_low(nvBusy, 8 * CPM, k);
      csw_host_model_i.rd(rv);
      chk("bit2 step", 8'h4e, rv);
      mon2In <= 1'b0;
      mon3In <= 1'b1;
      repeat (6) @(posedge clk);
      csw_host_model_i.rd(rv);
      chk("flag clear", 8'h0e, rv);
      wp <= 1'b1;
      repeat (6) @(posedge clk);
      chk("protect", 8'h00, 8'({potV, potN, memOk}));
      csw_host_model_i.wr(8'h82, 1, ack);
      until_low(nvBusy, 8 * CPM, k);
      csw_host_model_i.rd(rv);
      chk("nv kept", 8'h08, rv & 8'h99);
      lockHit <= 1'b1;
      @(posedge clk);
      lockHit <= 1'b0;
      csw_host_model_i.rd(rv);
      chk("lock hit", 8'h0a, rv);
      csw_host_model_i.wr(8'h00, 1, ack);
      chk("ack clear", 8'h01, 8'(ack));
      csw_host_model_i.rd(rv);
      chk("wel clear", 8'h08, rv);
      wp <= 1'b0;
      below <= 1'b1;
      manual <= 1'b1;
      repeat (3 * CPM) @(posedge clk);
      below <= 1'b0;
      repeat (CPM) @(posedge clk);
      chk("manual high", 8'h01, 8'(rstOut));
      manual <= 1'b0;
      until_low(rstOut, 60 * CPM, k);
      chk("hold 50", 8'h01, 8'((k >= 49 * CPM) && (k <= 52 * CPM)));
      give_verdict();
   end
endmodule // csw_control_status_write_protect_test
`default_nettype wire
